// >>> rtl/s2cc_params.svh
// offsets, field positions, reset values and bus codes of the stage 2 context control block
`ifndef S2CC_PARAMS_SVH
`define S2CC_PARAMS_SVH
`define S2CC_CTRL_OFS 12'h000
`define S2CC_STAT_OFS 12'h004
`define S2CC_CMD_OFS 12'h008
`define S2CC_CTRL_RST 32'h0000_0000
`define S2CC_CTRL_WMASK 32'h0FEF_E1E1
`define S2CC_EN_BIT 0
`define S2CC_ABT_BIT 5
`define S2CC_IRQ_BIT 6
`define S2CC_STL_BIT 7
`define S2CC_HUF_BIT 8
`define S2CC_PTW_BIT 13
`define S2CC_BSU_LSB 14
`define S2CC_MT_LSB 16
`define S2CC_FB_BIT 21
`define S2CC_SH_LSB 22
`define S2CC_RA_LSB 24
`define S2CC_WA_LSB 26
`define S2CC_ST_FLT_BIT 0
`define S2CC_ST_STALL_BIT 1
`define S2CC_ST_IRQ_BIT 2
`define S2CC_CMD_RESUME_BIT 0
`define S2CC_CMD_KILL_BIT 1
`define S2CC_RESP_OKAY 2'h0
`define S2CC_RESP_SLVERR 2'h2
`endif

// >>> rtl/s2cc_pkg.sv
// types shared by the stage 2 context control block
`default_nettype none
package s2cc_pkg;
    // fault sequencer: running, or holding a stalled faulting transaction
    typedef enum logic {
        FS_RUN,
        FS_STALL
    } s2cc_fstate_t;
endpackage : s2cc_pkg
`default_nettype wire

// >>> rtl/s2cc_axil_slave.sv
// axi4-lite slave front end turning bus transfers into register strobes
`default_nettype none
`include "s2cc_params.svh"
module s2cc_axil_slave #(
    parameter int ADDR_W = 12
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, low
    input wire logic [ADDR_W-1:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte enables
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [ADDR_W-1:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output logic reg_wr_en, // one-cycle write strobe
    output logic [ADDR_W-1:0] reg_wr_addr, // write address to decode
    output logic [31:0] reg_wr_data, // write data
    output logic [3:0] reg_wr_strb, // write byte enables
    input wire logic reg_wr_hit, // write address is mapped
    output logic [ADDR_W-1:0] reg_rd_addr, // read address to decode
    input wire logic [31:0] reg_rd_data, // read value
    input wire logic reg_rd_hit // read address is mapped
);
    logic aw_held_q;
    logic w_held_q;

    // address and data are taken in either order, nothing new while a response waits
    assign awready = !aw_held_q && !bvalid;
    assign wready = !w_held_q && !bvalid;
    assign reg_wr_en = aw_held_q && w_held_q && !bvalid;
    assign arready = !rvalid;
    assign reg_rd_addr = araddr;

    // write address holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            reg_wr_addr <= '0;
        end else if (awvalid && awready) begin
            aw_held_q <= 1'b1;
            reg_wr_addr <= awaddr;
        end else if (reg_wr_en) begin
            aw_held_q <= 1'b0;
        end
    end

    // write data holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            reg_wr_data <= '0;
            reg_wr_strb <= '0;
        end else if (wvalid && wready) begin
            w_held_q <= 1'b1;
            reg_wr_data <= wdata;
            reg_wr_strb <= wstrb;
        end else if (reg_wr_en) begin
            w_held_q <= 1'b0;
        end
    end

    // write response, one cycle after the strobe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `S2CC_RESP_OKAY;
        end else if (reg_wr_en) begin
            bvalid <= 1'b1;
            bresp <= reg_wr_hit ? `S2CC_RESP_OKAY : `S2CC_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read data captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `S2CC_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= reg_rd_hit ? reg_rd_data : 32'h0000_0000;
            rresp <= reg_rd_hit ? `S2CC_RESP_OKAY : `S2CC_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : s2cc_axil_slave
`default_nettype wire

// >>> rtl/s2cc_top.sv
// stage 2 context control register with its bypass, fault and barrier logic
// Function
// - translation off, write allocation hint follows write hint field; absent field reads zero.
// - translation off, read allocation hint follows read hint field; absent field reads zero.
// - translation off, shareability is the stronger of incoming shareability and share field; absent field reads zero.
// - stage 2 shareability combines with the incoming shareability, strongest wins.
// - force broadcast bit broadcasts tlb, predictor and icache maintenance from this context.
// - memory type overlay from the register only while translation is off.
// - stage 2 memory type combines with incoming memory type, strongest wins.
// - barrier domain raised to at least the barrier upgrade field.
// - without barrier upgrade support the field reads zero.
// - protected walk set: stage 1 walk into device memory raises a fault.
// - without nested translation the protected walk bit reads zero.
// - bits 12 and 11 to 9 hold nothing; they read zero here.
// - hit under fault clear: later transactions stall or terminate while fault outstanding.
// - no ordering promise between clients while a fault is outstanding.
// - fault terminates when stall select is 0, stalls when it is 1.
// - interrupt enable bit gates context fault interrupt signalling.
// - interrupt raised on fault only when enabled; enable resets to zero.
// - abort response returned for a fault only when abort enable is set.
// - fields unsupported downstream may read zero and ignore writes.
`default_nettype none
`include "s2cc_params.svh"
module s2cc_top #(
    parameter int ADDR_W = 12, // register bus address width
    parameter bit HAS_WA = 1'b1, // write hint field present
    parameter bit HAS_RA = 1'b1, // read hint field present
    parameter bit HAS_SH = 1'b1, // share field present
    parameter bit HAS_BSU = 1'b1, // barrier upgrade present
    parameter bit HAS_NESTED = 1'b1 // stage 1 then stage 2 present
) (
    input wire logic aclk, // clock, 125 mhz
    input wire logic aresetn, // sync reset, low
    input wire logic [ADDR_W-1:0] s_awaddr, // axi write address
    input wire logic s_awvalid, // axi write address valid
    output logic s_awready, // axi write address ready
    input wire logic [31:0] s_wdata, // axi write data
    input wire logic [3:0] s_wstrb, // axi byte enables
    input wire logic s_wvalid, // axi write data valid
    output logic s_wready, // axi write data ready
    output logic [1:0] s_bresp, // axi write response
    output logic s_bvalid, // axi write response valid
    input wire logic s_bready, // axi write response ready
    input wire logic [ADDR_W-1:0] s_araddr, // axi read address
    input wire logic s_arvalid, // axi read address valid
    output logic s_arready, // axi read address ready
    output logic [31:0] s_rdata, // axi read data
    output logic [1:0] s_rresp, // axi read response
    output logic s_rvalid, // axi read valid
    input wire logic s_rready, // axi read ready
    input wire logic in_valid, // client transaction valid
    output logic in_ready, // client transaction taken
    input wire logic in_write, // transaction is a write
    input wire logic in_walk, // stage 1 table walk access
    input wire logic [3:0] in_mem_type, // memory type from earlier step
    input wire logic [1:0] in_share, // shareability from earlier step
    input wire logic [3:0] xlat_mem_type, // stage 2 table memory type
    input wire logic [1:0] xlat_share, // stage 2 table shareability
    input wire logic xlat_fault, // stage 2 lookup faulted
    output logic out_valid, // downstream transaction valid
    input wire logic out_ready, // downstream ready
    output logic [3:0] out_mem_type, // final memory type
    output logic [1:0] out_share, // final shareability
    output logic [1:0] out_alloc, // final allocation hint
    output logic out_terminate, // transaction terminated
    output logic out_abort, // abort returned to client
    input wire logic barrier_valid, // client barrier
    input wire logic [1:0] barrier_domain, // requested barrier domain
    output logic barrier_out_valid, // barrier forwarded
    output logic [1:0] barrier_out_domain, // upgraded barrier domain
    input wire logic maint_valid, // maintenance operation issued
    input wire logic maint_bcast_req, // operation asks for broadcast
    output logic maint_out_valid, // maintenance forwarded
    output logic maint_out_bcast, // forwarded as broadcast
    output logic fault_irq // context fault interrupt
);
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] wmask;
    logic [31:0] rd_data;
    logic fault_pending_q;
    s2cc_pkg::s2cc_fstate_t fstate_q;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [ADDR_W-1:0] rd_addr;
    logic wr_hit;
    logic rd_hit;
    logic en;
    logic acc;
    logic fault_now;
    logic blk_term;
    logic blk_stall;
    logic out_free;
    logic cmd_resume;
    logic cmd_kill;
    logic flt_clr;
    logic [3:0] mem_d;
    logic [1:0] share_d;
    logic [1:0] alloc_d;

    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
        $error("s2cc_top: ADDR_W must lie in 4..32");
    end

    // mapped word test, low two address bits ignored
    function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        is_reg = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(ofs));
    endfunction : is_reg

    // rank of a shareability code: non, inner, outer
    function automatic logic [1:0] sh_rank(input logic [1:0] s);
        unique case (s)
            2'b01: sh_rank = 2'd2;
            2'b10: sh_rank = 2'd1;
            default: sh_rank = 2'd0;
        endcase
    endfunction : sh_rank

    // the stronger of two shareability codes
    function automatic logic [1:0] sh_comb(input logic [1:0] a, input logic [1:0] b);
        sh_comb = (sh_rank(a) >= sh_rank(b)) ? a : b;
    endfunction : sh_comb

    // the stronger of two memory types; lower codes are the more ordered kinds
    function automatic logic [3:0] mt_comb(input logic [3:0] a, input logic [3:0] b);
        mt_comb = (a < b) ? a : b;
    endfunction : mt_comb

    // device or strongly-ordered memory type
    function automatic logic is_dev(input logic [3:0] m);
        is_dev = (m[3:2] == 2'b00);
    endfunction : is_dev

    s2cc_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_awaddr),
        .awvalid(s_awvalid),
        .awready(s_awready),
        .wdata(s_wdata),
        .wstrb(s_wstrb),
        .wvalid(s_wvalid),
        .wready(s_wready),
        .bresp(s_bresp),
        .bvalid(s_bvalid),
        .bready(s_bready),
        .araddr(s_araddr),
        .arvalid(s_arvalid),
        .arready(s_arready),
        .rdata(s_rdata),
        .rresp(s_rresp),
        .rvalid(s_rvalid),
        .rready(s_rready),
        .reg_wr_en(wr_en),
        .reg_wr_addr(wr_addr),
        .reg_wr_data(wr_data),
        .reg_wr_strb(wr_strb),
        .reg_wr_hit(wr_hit),
        .reg_rd_addr(rd_addr),
        .reg_rd_data(rd_data),
        .reg_rd_hit(rd_hit)
    );

    assign wr_hit = is_reg(wr_addr, `S2CC_CTRL_OFS) || is_reg(wr_addr, `S2CC_STAT_OFS)
                    || is_reg(wr_addr, `S2CC_CMD_OFS);
    assign rd_hit = is_reg(rd_addr, `S2CC_CTRL_OFS) || is_reg(rd_addr, `S2CC_STAT_OFS)
                    || is_reg(rd_addr, `S2CC_CMD_OFS);

    // writable bits: absent features stay zero, bits 20 and 12..9 never store
    always_comb begin
        wmask = `S2CC_CTRL_WMASK;
        if (!HAS_WA) wmask[`S2CC_WA_LSB +: 2] = 2'b00;
        if (!HAS_RA) wmask[`S2CC_RA_LSB +: 2] = 2'b00;
        if (!HAS_SH) wmask[`S2CC_SH_LSB +: 2] = 2'b00;
        if (!HAS_BSU) wmask[`S2CC_BSU_LSB +: 2] = 2'b00;
        if (!HAS_NESTED) wmask[`S2CC_PTW_BIT] = 1'b0;
        ctrl_d = ctrl_q;
        for (int i = 0; i < 4; i++) begin
            if (wr_strb[i]) begin
                ctrl_d[i*8 +: 8] = (wr_data[i*8 +: 8] & wmask[i*8 +: 8])
                                   | (ctrl_q[i*8 +: 8] & ~wmask[i*8 +: 8]);
            end
        end
    end

    // control register; masked bits hold zero so reads show zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `S2CC_CTRL_RST;
        end else if (wr_en && is_reg(wr_addr, `S2CC_CTRL_OFS)) begin
            ctrl_q <= ctrl_d;
        end
    end

    // register read mux, command register reads zero
    always_comb begin
        rd_data = 32'h0000_0000;
        if (is_reg(rd_addr, `S2CC_CTRL_OFS)) begin
            rd_data = ctrl_q;
        end else if (is_reg(rd_addr, `S2CC_STAT_OFS)) begin
            rd_data[`S2CC_ST_FLT_BIT] = fault_pending_q;
            rd_data[`S2CC_ST_STALL_BIT] = (fstate_q == s2cc_pkg::FS_STALL);
            rd_data[`S2CC_ST_IRQ_BIT] = fault_irq;
        end
    end

    // software strobes: status write-one-to-clear and stall commands
    assign flt_clr = wr_en && is_reg(wr_addr, `S2CC_STAT_OFS) && wr_strb[0]
                     && wr_data[`S2CC_ST_FLT_BIT];
    assign cmd_resume = wr_en && is_reg(wr_addr, `S2CC_CMD_OFS) && wr_strb[0]
                        && wr_data[`S2CC_CMD_RESUME_BIT];
    assign cmd_kill = wr_en && is_reg(wr_addr, `S2CC_CMD_OFS) && wr_strb[0]
                      && wr_data[`S2CC_CMD_KILL_BIT];

    // transaction acceptance and fault detection
    assign en = ctrl_q[`S2CC_EN_BIT];
    assign out_free = !out_valid || out_ready;
    assign fault_now = en && (xlat_fault || (ctrl_q[`S2CC_PTW_BIT] && in_walk
                       && is_dev(xlat_mem_type)));
    // clients are held per context, with no ordering promise across clients
    assign blk_stall = fault_pending_q && !ctrl_q[`S2CC_HUF_BIT]
                       && ctrl_q[`S2CC_STL_BIT];
    assign blk_term = fault_pending_q && !ctrl_q[`S2CC_HUF_BIT]
                      && !ctrl_q[`S2CC_STL_BIT];
    assign in_ready = out_free && (fstate_q == s2cc_pkg::FS_RUN) && !blk_stall;
    assign acc = in_valid && in_ready;

    // attribute selection between bypass and stage 2 paths
    always_comb begin
        if (!en) begin
            mem_d = mt_comb(in_mem_type, ctrl_q[`S2CC_MT_LSB +: 4]);
            share_d = sh_comb(in_share, ctrl_q[`S2CC_SH_LSB +: 2]);
            alloc_d = in_write ? ctrl_q[`S2CC_WA_LSB +: 2]
                               : ctrl_q[`S2CC_RA_LSB +: 2];
        end else begin
            mem_d = mt_comb(in_mem_type, xlat_mem_type);
            share_d = sh_comb(in_share, xlat_share);
            alloc_d = 2'b00;
        end
    end

    // fault sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fstate_q <= s2cc_pkg::FS_RUN;
        end else begin
            unique case (fstate_q)
                s2cc_pkg::FS_RUN:
                    if (acc && fault_now && ctrl_q[`S2CC_STL_BIT]) begin
                        fstate_q <= s2cc_pkg::FS_STALL;
                    end
                s2cc_pkg::FS_STALL:
                    if (cmd_resume || cmd_kill) begin
                        fstate_q <= s2cc_pkg::FS_RUN;
                    end
            endcase
        end
    end

    // outstanding fault flag, a new fault wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_pending_q <= 1'b0;
        end else if (acc && fault_now) begin
            fault_pending_q <= 1'b1;
        end else if (flt_clr) begin
            fault_pending_q <= 1'b0;
        end
    end

    // interrupt is gated by its enable
    assign fault_irq = fault_pending_q && ctrl_q[`S2CC_IRQ_BIT];

    // downstream output stage; a stalled transaction waits here unseen
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid <= 1'b0;
            out_mem_type <= 4'h0;
            out_share <= 2'h0;
            out_alloc <= 2'h0;
            out_terminate <= 1'b0;
            out_abort <= 1'b0;
        end else if (acc) begin
            out_mem_type <= mem_d;
            out_share <= share_d;
            out_alloc <= alloc_d;
            out_valid <= !(fault_now && ctrl_q[`S2CC_STL_BIT]);
            out_terminate <= fault_now || blk_term;
            out_abort <= (fault_now || blk_term) && ctrl_q[`S2CC_ABT_BIT];
        end else if (fstate_q == s2cc_pkg::FS_STALL && (cmd_resume || cmd_kill)) begin
            out_valid <= 1'b1;
            out_terminate <= cmd_kill;
            out_abort <= cmd_kill && ctrl_q[`S2CC_ABT_BIT];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    // barrier domain upgrade, strongest of request and field
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            barrier_out_valid <= 1'b0;
            barrier_out_domain <= 2'h0;
        end else begin
            barrier_out_valid <= barrier_valid;
            if (barrier_valid) begin
                barrier_out_domain <= (barrier_domain > ctrl_q[`S2CC_BSU_LSB +: 2])
                    ? barrier_domain : ctrl_q[`S2CC_BSU_LSB +: 2];
            end
        end
    end

    // maintenance forwarding, broadcast forced by the control bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            maint_out_valid <= 1'b0;
            maint_out_bcast <= 1'b0;
        end else begin
            maint_out_valid <= maint_valid;
            maint_out_bcast <= maint_valid && (maint_bcast_req || ctrl_q[`S2CC_FB_BIT]);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_stall_fault;
        acc && fault_now && ctrl_q[`S2CC_STL_BIT];
    endsequence

    sequence s_resume_cmd;
        (fstate_q == s2cc_pkg::FS_STALL) && cmd_resume && !cmd_kill;
    endsequence

    chk_wa_bypass: assert property (acc && !en && in_write |=>
        out_alloc == $past(ctrl_q[`S2CC_WA_LSB +: 2]))
        else $error("write hint not taken from register");
    chk_ra_bypass: assert property (acc && !en && !in_write |=>
        out_alloc == $past(ctrl_q[`S2CC_RA_LSB +: 2]))
        else $error("read hint not taken from register");
    chk_share_comb: assert property (acc && !en |=>
        sh_rank(out_share) >= sh_rank($past(ctrl_q[`S2CC_SH_LSB +: 2])))
        else $error("bypass share weaker than field");
    chk_mem_xlat: assert property (acc && en |=>
        out_mem_type == mt_comb($past(in_mem_type), $past(xlat_mem_type)))
        else $error("memory overlay while translating");
    chk_force_bcast: assert property (maint_valid && ctrl_q[`S2CC_FB_BIT] |=>
        maint_out_valid && maint_out_bcast)
        else $error("forced broadcast missing");
    chk_barrier_floor: assert property (barrier_valid |=>
        barrier_out_domain >= $past(ctrl_q[`S2CC_BSU_LSB +: 2]))
        else $error("barrier not upgraded");
    chk_walk_fault: assert property (acc && en && ctrl_q[`S2CC_PTW_BIT] && in_walk
        && is_dev(xlat_mem_type) |=> fault_pending_q)
        else $error("protected walk fault not raised");
    chk_huf_hold: assert property (acc && fault_pending_q && !ctrl_q[`S2CC_HUF_BIT]
        |=> out_terminate)
        else $error("transaction passed under outstanding fault");
    chk_fault_term: assert property (acc && fault_now && !ctrl_q[`S2CC_STL_BIT] |=>
        out_valid && out_terminate && out_abort == $past(ctrl_q[`S2CC_ABT_BIT]))
        else $error("terminating fault not signalled");
    chk_stall_hold: assert property (s_stall_fault |=> !out_valid && !in_ready)
        else $error("stalled transaction not held");
    chk_stall_resume: assert property (s_resume_cmd |=> out_valid && !out_terminate)
        else $error("stalled transaction not resumed");
    chk_irq_gate: assert property (acc && fault_now |=> fault_irq == ctrl_q[`S2CC_IRQ_BIT])
        else $error("fault interrupt gating wrong");
    chk_abort_gate: assert property (acc && !ctrl_q[`S2CC_ABT_BIT] |=> !out_abort)
        else $error("abort without abort enable");
endmodule : s2cc_top
`default_nettype wire

// >>> dv/s2cc_sink.sv
// downstream interconnect model giving prompt or stalling ready
`default_nettype none
module s2cc_sink (
    input wire logic aclk, // clock
    input wire logic slow, // stall on alternate cycles
    output logic out_ready // ready toward the block
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog_q = 1'b0;
    // alternate stalls keep the output stage full across edges
    always_ff @(posedge aclk) begin
        tog_q <= ~tog_q;
        out_ready <= !slow | tog_q;
    end
endmodule : s2cc_sink
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench of the stage 2 context control block
`default_nettype none
`include "s2cc_params.svh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
    logic s_rready = 0, in_valid = 0, in_write = 0, in_walk = 0, xlat_fault = 0, slow = 0;
    logic barrier_valid = 0, maint_valid = 0, maint_bcast_req = 0, out_ready;
    logic [11:0] s_awaddr = 0, s_araddr = 0;
    logic [31:0] s_wdata = 0, s_rdata, d, rd;
    logic [3:0] s_wstrb = 4'hf, in_mem_type = 0, xlat_mem_type = 0, out_mem_type;
    logic [1:0] in_share = 0, xlat_share = 0, barrier_domain = 0, s_bresp, s_rresp, rr;
    logic [1:0] out_share, out_alloc, barrier_out_domain;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, in_ready, out_valid;
    logic out_terminate, out_abort, barrier_out_valid, maint_out_valid, maint_out_bcast, fault_irq;
    int err_count = 0, check_count = 0, cyc = 0, seed = 32'h8977_d7dc;
    s2cc_top DUT (.*);
    s2cc_sink sink (.aclk(aclk), .slow(slow), .out_ready(out_ready));
    initial forever #4 aclk = ~aclk;
    // runaway guard; the whole sequence needs a few hundred cycles
    always @(posedge aclk) if (++cyc == 20000) begin err_count++; test_done(); end
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    function automatic int rk(input logic [1:0] s);
        return s == 2'h1 ? 2 : (s == 2'h2 ? 1 : 0);
    endfunction : rk
    // axi write: both halves offered together, each dropped once taken
    task automatic axw(input logic [11:0] a, input logic [31:0] v);
        logic ta = 0, tw = 0, b = 0;
        s_awaddr <= a; s_wdata <= v; s_awvalid <= 1; s_wvalid <= 1; s_bready <= 1;
        while (!(ta && tw)) begin
            @(negedge aclk); ta |= s_awvalid & s_awready; tw |= s_wvalid & s_wready;
            @(posedge aclk); if (ta) s_awvalid <= 0; if (tw) s_wvalid <= 0;
        end
        while (!b) begin @(negedge aclk); b = s_bvalid; rr = s_bresp; @(posedge aclk); end
        s_bready <= 0;
        @(posedge aclk);
    endtask : axw
    task automatic axr(input logic [11:0] a);
        logic t = 0, r = 0;
        s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
        while (!t) begin @(negedge aclk); t = s_arready; @(posedge aclk); end
        s_arvalid <= 0;
        while (!r) begin @(negedge aclk); r = s_rvalid; rd = s_rdata; rr = s_rresp; @(posedge aclk); end
        s_rready <= 0;
        @(posedge aclk);
    endtask : axr
    // client transaction held until taken, result caught at the downstream handshake
    task automatic tx(input logic [31:0] r, input logic f);
        logic t = 0, o = 0;
        {in_write, in_walk, in_mem_type, in_share, xlat_mem_type, xlat_share} <= r[13:0];
        xlat_fault <= f; in_valid <= 1;
        while (!t) begin @(negedge aclk); t = in_ready; @(posedge aclk); end
        in_valid <= 0; xlat_fault <= ~f;
        while (!o) begin @(negedge aclk); o = out_valid & out_ready; @(posedge aclk); end
    endtask : tx
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        axr(`S2CC_CTRL_OFS); `CHK("ctrl reset", 32'h0000_0000, rd)
        axr(12'h00C); `CHK("unmapped resp", `S2CC_RESP_SLVERR, rr) `CHK("unmapped data", 32'h0, rd)
        for (int i = 0; i < 12; i++) begin
            slow <= i[0];
            d = $random(seed) & 32'hFFFF_FFFE;
            if (i == 0) d = 32'hFFFF_FFFE;
            axw(`S2CC_CTRL_OFS, d); axr(`S2CC_CTRL_OFS);
            `CHK("ctrl readback", d & `S2CC_CTRL_WMASK, rd)
            d &= `S2CC_CTRL_WMASK;
            barrier_valid <= 1; barrier_domain <= 2'($random(seed));
            maint_valid <= 1; maint_bcast_req <= 1'($random(seed));
            @(posedge aclk); barrier_valid <= 0; maint_valid <= 0;
            @(negedge aclk);
            `CHK("barrier valid", 1'b1, barrier_out_valid)
            `CHK("barrier dom", (barrier_domain > d[15:14]) ? barrier_domain : d[15:14],
                barrier_out_domain)
            `CHK("maint bcast", maint_bcast_req | d[21], maint_out_bcast)
            `CHK("maint valid", 1'b1, maint_out_valid)
            @(posedge aclk);
            tx($random(seed), 0);
            `CHK("mem type", in_mem_type < d[19:16] ? in_mem_type : d[19:16], out_mem_type)
            `CHK("share rank", rk(in_share) > rk(d[23:22]) ? rk(in_share) : rk(d[23:22]),
                rk(out_share))
            `CHK("alloc", in_write ? d[27:26] : d[25:24], out_alloc)
            `CHK("no term", 1'b0, out_terminate)
        end
        // protected walk into device memory faults and terminates
        axw(`S2CC_CTRL_OFS, 32'h0000_2061);
        tx(32'h0000_1141, 0);
        `CHK("terminate", 1'b1, out_terminate)
        `CHK("abort", 1'b1, out_abort)
        `CHK("xlat alloc", 2'h0, out_alloc)
        @(negedge aclk); `CHK("irq", 1'b1, fault_irq)
        @(posedge aclk);
        tx(32'h0000_0000, 0); `CHK("term pending", 1'b1, out_terminate)
        // stalled fault, released by the resume command
        axw(`S2CC_STAT_OFS, 32'h0000_0001); axw(`S2CC_CTRL_OFS, 32'h0000_00A1);
        fork
            tx(32'h0000_0000, 1);
            begin
                repeat (4) @(posedge aclk);
                axr(`S2CC_STAT_OFS); `CHK("stalled", 32'h0000_0003, rd)
                axw(`S2CC_CMD_OFS, 32'h0000_0001);
            end
        join
        `CHK("resumed", 1'b0, out_terminate)
        `CHK("irq off", 1'b0, fault_irq)
        test_done();
    end
endmodule : testbench
`default_nettype wire
